// ==== verilog/rsr_defines.vh ====
// Offsets, field positions, codes and reset values for the radio status bank
`ifndef RSR_DEFINES_VH
`define RSR_DEFINES_VH
`define RSR_ADDR_W          16
`define RSR_REG_REVISION    16'hdf37
`define RSR_REG_OFFSET_EST  16'hdf38
`define RSR_REG_LINK_QUAL   16'hdf39
`define RSR_REG_SIG_LEVEL   16'hdf3a
`define RSR_REG_FSM_STATE   16'hdf3b
`define RSR_REG_PKT_FLAGS   16'hdf3c
`define RSR_REG_VCO_TUNE    16'hdf3d
`define RSR_REG_IRQ_STATUS  16'hdf3e
`define RSR_REG_IRQ_MASK    16'hdf3f
`define RSR_REG_MOD_SEL     16'hdf40
// Arbitrary neutral revision code
`define RSR_REVISION_CODE   8'h5a
`define RSR_PKT_CRC_BIT     7
`define RSR_PKT_CS_BIT      6
`define RSR_PKT_PQT_BIT     5
`define RSR_PKT_CCA_BIT     4
`define RSR_PKT_SFD_BIT     3
`define RSR_PKT_RESET       8'h00
`define RSR_OFFSET_STEP_LOG2 14
`define RSR_LQ_SYMBOLS      64
`define RSR_LQ_BYTES_2ARY   8
`define RSR_LQ_BYTES_4ARY   16
`define RSR_FSM_MAX         5'h16
`define RSR_FSM_RX          5'h0d
`define RSR_FSM_RX_RST      5'h0f
`define RSR_MOD_FSK2        3'h0
`define RSR_MOD_GFSK        3'h1
`define RSR_MOD_OOK         3'h3
`define RSR_MOD_FSK4        3'h4
`define RSR_MOD_MSK         3'h7
`define RSR_MOD_RESET       3'h0
`define RSR_IRQ_CRC_BIT     0
`define RSR_IRQ_SFD_BIT     1
`define RSR_IRQ_LQ_BIT      2
`define RSR_IRQ_ERR_BIT     3
`define RSR_IRQ_W           4
`endif

// ==== verilog/rsr_lq_acc.v ====
// Link quality accumulator over the symbols following the sync word
`include "rsr_defines.vh"
module rsr_lq_acc #(
  parameter SYMBOLS = `RSR_LQ_SYMBOLS
) (
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  input  wire       start_i,
  input  wire       sym_i,
  input  wire [6:0] sym_quality_i,
  output reg  [6:0] quality_o,
  output reg        done_o
);
  reg [6:0]  cnt_q;
  reg [12:0] sum_q;
  reg        run_q;
  wire [12:0] sum_d = sum_q + {6'h00, sym_quality_i};

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_q     <= 7'h00;
      sum_q     <= 13'h0000;
      run_q     <= 1'b0;
      quality_o <= 7'h00;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= 7'h00;
        sum_q <= 13'h0000;
        run_q <= 1'b1;
      end else if (run_q && sym_i) begin
        // Average over a fixed window: 64 symbols = 8 bytes 2-ary, 16 4-ary
        if (cnt_q == SYMBOLS[6:0] - 7'h01) begin
          quality_o <= sum_d[12:6];
          done_o    <= 1'b1;
          run_q     <= 1'b0;
        end else begin
          sum_q <= sum_d;
          cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end
endmodule

// ==== verilog/rsr_radio_status.v ====
// Radio status register bank with Wishbone slave and status interrupt
//
// The implementer's own choice: the Wishbone slave port.
`include "rsr_defines.vh"
module rsr_radio_status #(
  parameter LQ_SYMBOLS = `RSR_LQ_SYMBOLS
) (
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Demodulator and packet engine, same clock
  input  wire [7:0]  freq_offset_i,
  input  wire        offset_valid_i,
  input  wire [7:0]  signal_strength_level_i,
  input  wire [4:0]  fsm_code_i,
  input  wire        crc_done_i,
  input  wire        crc_match_i,
  input  wire        sym_tick_i,
  input  wire [6:0]  sym_quality_i,
  input  wire        sync_found_i,
  input  wire [7:0]  vco_tune_i,
  // Pin-level flags from the radio front end, asynchronous
  input  wire        carrier_sense_i,
  input  wire        preamble_quality_i,
  input  wire        clear_channel_i,
  input  wire        frame_start_i,
  input  wire [1:0]  power_mode_i,
  output reg  [7:0]  comp_offset_o,
  output reg         regulator_en_o,
  output reg         irq_o
);
  localparam [1:0] PM_TWO   = 2'h2;
  localparam [1:0] PM_THREE = 2'h3;

  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;
  reg [7:0] offset_q;
  reg [7:0] signal_strength_level_q;
  reg [4:0] fsm_q;
  reg [4:0] fsm_prev_q;
  reg [7:0] vco_q;
  reg       crc_ok_q;
  reg [4:0] pkt_q;
  reg [2:0] mod_q;
  reg [`RSR_IRQ_W-1:0] irq_stat_q;
  reg [`RSR_IRQ_W-1:0] irq_mask_q;
  reg [`RSR_IRQ_W-1:0] irq_set;
  reg [`RSR_IRQ_W-1:0] irq_clr;
  reg [31:0] rd_data;
  wire [6:0] lq_val;
  wire       lq_done;
  wire       wr_mod;
  wire       wr_mask;
  wire       wr_irq;
  wire [`RSR_IRQ_W-1:0] irq_next;

  function is_rx_code;
    input [4:0] code;
    begin
      is_rx_code = (code >= `RSR_FSM_RX) && (code <= `RSR_FSM_RX_RST);
    end
  endfunction

  // Codes above the last defined state are treated as corrupt
  function fsm_code_ok;
    input [4:0] code;
    begin
      fsm_code_ok = (code <= `RSR_FSM_MAX);
    end
  endfunction

  function [7:0] sat_offset;
    input [2:0] mode;
    input [7:0] est;
    begin
      if (mode == `RSR_MOD_OOK) begin
        sat_offset = 8'h00;
      end else begin
        sat_offset = est;
      end
    end
  endfunction

  // Core logic except the link quality accumulator and bus writes to mode, mask and status only updates while regulator is up; contents otherwise held
  wire powered    = regulator_en_o;
  wire rx_entry   = (fsm_code_i == `RSR_FSM_RX_RST) ||
                    (is_rx_code(fsm_code_i) && !is_rx_code(fsm_prev_q));
  wire fsk_like   = (mod_q == `RSR_MOD_FSK2) || (mod_q == `RSR_MOD_GFSK) ||
                    (mod_q == `RSR_MOD_FSK4) || (mod_q == `RSR_MOD_MSK);
  wire wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Only the low byte lane carries data
  wire wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_mod  = wb_wr && (wb_adr_i == `RSR_REG_MOD_SEL);
  assign wr_mask = wb_wr && (wb_adr_i == `RSR_REG_IRQ_MASK);
  assign wr_irq  = wb_wr && (wb_adr_i == `RSR_REG_IRQ_STATUS);

  // Synchronised front-end flags, in packet flag order
  wire cs_sync = pin_s2_q[3];
  wire pq_sync = pin_s2_q[2];
  wire cc_sync = pin_s2_q[1];
  wire fs_sync = pin_s2_q[0];

  rsr_lq_acc #(
    .SYMBOLS       (LQ_SYMBOLS)
  ) u_lq (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .start_i       (sync_found_i),
    .sym_i         (sym_tick_i),
    .sym_quality_i (sym_quality_i),
    .quality_o     (lq_val),
    .done_o        (lq_done)
  );

  // Two-flop synchronisers for the asynchronous flags and power mode
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {carrier_sense_i, preamble_quality_i,
                   clear_channel_i, frame_start_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  reg [1:0] pm_s1_q;
  reg [1:0] pm_s2_q;
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pm_s1_q <= 2'h0;
      pm_s2_q <= 2'h0;
    end else begin
      pm_s1_q <= power_mode_i;
      pm_s2_q <= pm_s1_q;
    end
  end

  // Regulator control follows synchronised power mode
  // Decoded from the synchronised copy; the raw pins are never read
  wire deep_mode_s = (pm_s2_q == PM_TWO) || (pm_s2_q == PM_THREE);
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      regulator_en_o <= 1'b1;
    end else begin
      regulator_en_o <= !deep_mode_s;
    end
  end

  // Offset estimate, taken only when the demodulator marks it valid
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      offset_q <= 8'h00;
    end else if (powered && offset_valid_i) begin
      offset_q <= freq_offset_i;
    end
  end

  // Signal strength is a plain sample, held while unpowered
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      signal_strength_level_q <= 8'h00;
    end else if (powered) begin
      signal_strength_level_q <= signal_strength_level_i;
    end
  end

  // Tuning value is for test readback only
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      vco_q <= 8'h00;
    end else if (powered) begin
      vco_q <= vco_tune_i;
    end
  end

  // Out-of-range codes keep the last good state for software
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fsm_q <= 5'h00;
    end else if (powered && fsm_code_ok(fsm_code_i)) begin
      fsm_q <= fsm_code_i;
    end
  end

  // Previous code, for spotting entry into the receive states
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fsm_prev_q <= 5'h00;
    end else if (powered) begin
      fsm_prev_q <= fsm_code_i;
    end
  end

  // Clear on receive entry wins over a checksum result in the same cycle
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      crc_ok_q <= 1'b0;
    end else if (powered) begin
      if (rx_entry)
        crc_ok_q <= 1'b0;
      else if (crc_done_i)
        crc_ok_q <= crc_match_i;
    end
  end

  // Front-end flags arrive three cycles late through the synchroniser
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pkt_q <= 5'h00;
    end else if (powered) begin
      pkt_q <= {1'b0, cs_sync, pq_sync, cc_sync, fs_sync};
    end
  end

  // Compensation output: step is crystal/2^14, zero unless FSK or MSK
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      comp_offset_o <= 8'h00;
    end else if (powered) begin
      comp_offset_o <= fsk_like ? offset_q : 8'h00;
    end
  end

  // Modulation select and interrupt mask are the only writable state besides write-one-to-clear interrupt status
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mod_q <= `RSR_MOD_RESET;
    end else if (wr_mod) begin
      mod_q <= wb_dat_i[2:0];
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_mask_q <= {`RSR_IRQ_W{1'b0}};
    end else if (wr_mask) begin
      irq_mask_q <= wb_dat_i[`RSR_IRQ_W-1:0];
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always @* begin
    irq_set = {`RSR_IRQ_W{1'b0}};
    irq_set[`RSR_IRQ_CRC_BIT] = powered && crc_done_i && crc_match_i;
    irq_set[`RSR_IRQ_SFD_BIT] = powered && sync_found_i;
    irq_set[`RSR_IRQ_LQ_BIT]  = powered && lq_done;
    irq_set[`RSR_IRQ_ERR_BIT] = powered && !fsm_code_ok(fsm_code_i);
    irq_clr = {`RSR_IRQ_W{1'b0}};
    if (wr_irq) begin
      irq_clr = wb_dat_i[`RSR_IRQ_W-1:0];
    end
  end

  // Status and interrupt line see the same next value
  assign irq_next = (irq_stat_q & ~irq_clr) | irq_set;

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_stat_q <= {`RSR_IRQ_W{1'b0}};
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= irq_next;
      irq_o      <= |(irq_next & irq_mask_q);
    end
  end

  // Read mux; status registers other than interrupt status have no write path at all
  always @* begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `RSR_REG_REVISION: begin
        rd_data[7:0] = `RSR_REVISION_CODE;
      end
      `RSR_REG_OFFSET_EST: begin
        rd_data[7:0] = sat_offset(mod_q, offset_q);
      end
      `RSR_REG_LINK_QUAL: begin
        rd_data[7:0] = {crc_ok_q, lq_val};
      end
      `RSR_REG_SIG_LEVEL: begin
        rd_data[7:0] = signal_strength_level_q;
      end
      `RSR_REG_FSM_STATE: begin
        rd_data[7:0] = {3'h0, fsm_q};
      end
      `RSR_REG_PKT_FLAGS: begin
        rd_data[7:0] = {crc_ok_q, pkt_q[3:0], 3'h0};
      end
      `RSR_REG_VCO_TUNE: begin
        rd_data[7:0] = vco_q;
      end
      `RSR_REG_IRQ_STATUS: begin
        rd_data[`RSR_IRQ_W-1:0] = irq_stat_q;
      end
      `RSR_REG_IRQ_MASK: begin
        rd_data[`RSR_IRQ_W-1:0] = irq_mask_q;
      end
      `RSR_REG_MOD_SEL: begin
        rd_data[2:0] = mod_q;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // One-cycle answer; writes to read-only offsets are acked and dropped
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data stands until the next read is answered
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end
endmodule

// ==== verif/rsr_status_asserts.sv ====
// Port-level checks for the radio status register bank
`include "rsr_defines.vh"
module rsr_status_asserts (
  input wire        sys_clk_i,
  input wire        resetn_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [1:0]  power_mode_i,
  input wire [7:0]  comp_offset_o,
  input wire        regulator_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    s_req ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  AST_ACK_TAKEN: assert property (s_req |=> wb_ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_BYTE: assert property (s_rd(`RSR_REG_SIG_LEVEL)
    |=> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  AST_PKT_LOW: assert property (s_rd(`RSR_REG_PKT_FLAGS)
    |=> wb_dat_o[2:0] == 3'h0) else $error("unused flag bits set");
  AST_FSM_CODE: assert property (s_rd(`RSR_REG_FSM_STATE)
    |=> wb_dat_o[7:5] == 3'h0 && wb_dat_o[4:0] <= `RSR_FSM_MAX)
    else $error("bad state code read");
  // Five cycles covers the two-flop sync plus the output register
  AST_REG_OFF: assert property (power_mode_i[1] [*5]
    |-> !regulator_en_o) else $error("regulator on in deep mode");
  AST_REG_ON: assert property (!power_mode_i[1] [*5]
    |-> regulator_en_o) else $error("regulator off when awake");
  AST_HOLD_OFF: assert property (!regulator_en_o [*2]
    |-> $stable(comp_offset_o)) else $error("offset changed unpowered");
endmodule
bind rsr_radio_status rsr_status_asserts i_chk (.sys_clk_i, .resetn_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .power_mode_i, .comp_offset_o, .regulator_en_o);

// ==== verif/tb.sv ====
// Self-checking bench for the radio status register bank
`include "rsr_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0, wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0, wb_we_i = 1'b0, offset_valid_i = 1'b0;
  logic        crc_done_i = 1'b0, crc_match_i = 1'b0, sym_tick_i = 1'b0;
  logic        sync_found_i = 1'b0, carrier_sense_i = 1'b0;
  logic        preamble_quality_i = 1'b0, clear_channel_i = 1'b0;
  logic        frame_start_i = 1'b0, wb_ack_o, regulator_en_o, irq_o;
  logic [1:0]  power_mode_i = 2'h0;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [4:0]  fsm_code_i = 5'h01;
  logic [6:0]  sym_quality_i = 7'h00;
  logic [7:0]  freq_offset_i = 8'h00, signal_strength_level_i = 8'h00, vco_tune_i = 8'h00;
  logic [7:0]  comp_offset_o, rd, e;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [2:0]  mods [5] = '{`RSR_MOD_FSK2, `RSR_MOD_GFSK, `RSR_MOD_OOK,
                            `RSR_MOD_FSK4, `RSR_MOD_MSK};
  int          errors = 0, tests_run = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  rsr_radio_status i_dut (.sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
    .freq_offset_i, .offset_valid_i, .signal_strength_level_i, .fsm_code_i, .crc_done_i,
    .crc_match_i, .sym_tick_i, .sym_quality_i, .sync_found_i, .vco_tune_i,
    .carrier_sense_i, .preamble_quality_i, .clear_channel_i,
    .frame_start_i, .power_mode_i, .comp_offset_o, .regulator_en_o, .irq_o);
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Held until ack is seen; the next call lets one idle edge pass
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1 && n++ < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rc(string n, logic [15:0] a, logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(n, x, rd);
  endtask
  // 0 offset valid, 1 checksum done, 2 sync found, else symbol tick
  task automatic pulse(int k);
    @(posedge sys_clk_i);
    case (k)
      0: offset_valid_i <= 1'b1;
      1: crc_done_i <= 1'b1;
      2: sync_found_i <= 1'b1;
      default: sym_tick_i <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    offset_valid_i <= 1'b0;
    crc_done_i <= 1'b0;
    sync_found_i <= 1'b0;
    sym_tick_i <= 1'b0;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    idle(20000);
    errors++;
    stop_test;
  end
  initial begin
    idle(5);
    resetn_i <= 1'b1;
    rc("pkt", `RSR_REG_PKT_FLAGS, `RSR_PKT_RESET);
    chk("reg_en", 8'h01, {7'h0, regulator_en_o});
    signal_strength_level_i <= 8'hc3;
    vco_tune_i <= 8'h3c;
    for (int a = 'hdf37; a <= 'hdf3d; a++) bus(1'b1, a[15:0], 8'hff);
    rc("signal_strength_level", `RSR_REG_SIG_LEVEL, 8'hc3);
    rc("vco", `RSR_REG_VCO_TUNE, 8'h3c);
    rc("rev", `RSR_REG_REVISION, `RSR_REVISION_CODE);
    for (int c = 0; c <= 22; c++) begin
      fsm_code_i <= c[4:0];
      rc("fsm", `RSR_REG_FSM_STATE, c[7:0]);
    end
    $display("read-only test done");
    freq_offset_i <= 8'hf3;
    foreach (mods[i]) begin
      bus(1'b1, `RSR_REG_MOD_SEL, {5'h0, mods[i]});
      pulse(0);
      idle(2);
      e = (mods[i] == `RSR_MOD_OOK) ? 8'h00 : 8'hf3;
      rc("offset", `RSR_REG_OFFSET_EST, e);
      chk("comp", e, comp_offset_o);
    end
    $display("offset test done");
    fsm_code_i <= 5'h01;
    crc_match_i <= 1'b1;
    pulse(1);
    idle(2);
    rc("pkt_crc", `RSR_REG_PKT_FLAGS, 8'h80);
    bus(1'b0, `RSR_REG_LINK_QUAL, 8'h00);
    chk("lq_crc", 8'h01, {7'h0, rd[7]});
    rc("irq_st", `RSR_REG_IRQ_STATUS, 8'h01);
    chk("irq_masked", 8'h00, {7'h0, irq_o});
    bus(1'b1, `RSR_REG_IRQ_MASK, 8'h01);
    idle(3);
    chk("irq_on", 8'h01, {7'h0, irq_o});
    bus(1'b1, `RSR_REG_IRQ_STATUS, 8'h01);
    idle(3);
    chk("irq_off", 8'h00, {7'h0, irq_o});
    fsm_code_i <= `RSR_FSM_RX;
    idle(2);
    rc("crc_clr", `RSR_REG_PKT_FLAGS, 8'h00);
    $display("crc test done");
    pulse(2);
    sym_quality_i <= 7'h2a;
    repeat (`RSR_LQ_SYMBOLS) pulse(3);
    sym_quality_i <= 7'h00;
    pulse(3);
    idle(3);
    rc("lqi", `RSR_REG_LINK_QUAL, 8'h2a);
    carrier_sense_i <= 1'b1;
    preamble_quality_i <= 1'b1;
    frame_start_i <= 1'b1;
    idle(4);
    rc("flags", `RSR_REG_PKT_FLAGS, 8'h68);
    carrier_sense_i <= 1'b0;
    clear_channel_i <= 1'b1;
    idle(4);
    rc("flags2", `RSR_REG_PKT_FLAGS, 8'h38);
    $display("flag test done");
    power_mode_i <= 2'h3;
    idle(6);
    chk("reg_off", 8'h00, {7'h0, regulator_en_o});
    power_mode_i <= 2'h2;
    signal_strength_level_i <= 8'h5e;
    idle(6);
    rc("signal_strength_level_hold", `RSR_REG_SIG_LEVEL, 8'hc3);
    power_mode_i <= 2'h1;
    idle(6);
    chk("reg_on", 8'h01, {7'h0, regulator_en_o});
    rc("signal_strength_level_new", `RSR_REG_SIG_LEVEL, 8'h5e);
    bus(1'b1, 16'hdf50, 8'hff);
    rc("unmapped", 16'hdf50, 8'h00);
    $display("power test done");
    stop_test;
  end
endmodule
